// ==== src/cmb_pkg.sv ====
// Purpose: constants for the core memory bus fabric
// Assumes: one synchronous clock, memories answer one cycle after a request
// Notes: data address ranges are fixed decode windows
package cmb_pkg;
    localparam int PAB_W = 21;
    localparam int XAB_W = 24;
    localparam int WIDE_W = 32;
    localparam int NARROW_W = 16;
    localparam int XAB_MSB = 23;
    // decode windows on the primary data address (word address space)
    localparam logic [XAB_W-1:0] RAM_BASE = 24'h000000;
    localparam logic [XAB_W-1:0] RAM_LAST = 24'h000fff;
    localparam logic [XAB_W-1:0] DFL_BASE = 24'h004000;
    localparam logic [XAB_W-1:0] DFL_LAST = 24'h004fff;
    localparam logic [XAB_W-1:0] PER_BASE = 24'h00f000;
    localparam logic [XAB_W-1:0] PER_LAST = 24'h00ffff;
    localparam logic [WIDE_W-1:0] UNMAPPED_DATA = 32'h00000000;

    typedef enum logic [1:0] {
        CMB_SIZE_BYTE = 2'b00,
        CMB_SIZE_WORD = 2'b01,
        CMB_SIZE_LONG = 2'b10
    } cmb_size_type;

    typedef enum logic [1:0] {
        CMB_TGT_NONE = 2'b00,
        CMB_TGT_RAM = 2'b01,
        CMB_TGT_DFL = 2'b10,
        CMB_TGT_PER = 2'b11
    } cmb_tgt_type;
endpackage

// ==== src/cmb_fabric.sv ====
// Purpose: route core program, primary and secondary data accesses to memories
// Assumes: all targets sampled on clk, read data valid one cycle after request
// Notes: every output is registered; reads answer two cycles after the request
`timescale 1ns/1ps

module cmb_fabric
    import cmb_pkg::*;
(
    input wire logic clk,
    input wire logic reset_n,
    // core program side
    input wire logic [PAB_W-1:0] program_address_bus,
    input wire logic program_read_req,
    input wire logic program_write_req,
    output logic [NARROW_W-1:0] program_read_bus,
    // core primary data side
    input wire logic [XAB_W-1:0] primary_data_address_bus,
    input wire logic primary_read_req,
    input wire logic primary_write_req,
    input wire logic [1:0] primary_size,
    input wire logic [WIDE_W-1:0] core_write_bus,
    output logic [WIDE_W-1:0] primary_read_bus,
    // core secondary data side
    input wire logic [XAB_W-1:0] secondary_data_address_bus,
    input wire logic secondary_read_req,
    output logic [NARROW_W-1:0] secondary_read_bus,
    // program memory (flash module array and program ram)
    output logic [PAB_W-1:0] pmem_addr,
    output logic pmem_rd,
    output logic pmem_wr,
    output logic [NARROW_W-1:0] pmem_wdata,
    input wire logic [NARROW_W-1:0] pmem_rdata,
    // data ram primary port, 32 bits
    output logic [XAB_W-1:0] dram_addr,
    output logic dram_rd,
    output logic dram_wr,
    output logic [1:0] dram_size,
    output logic [WIDE_W-1:0] dram_wdata,
    input wire logic [WIDE_W-1:0] dram_rdata,
    // data ram secondary port, 16 bits
    output logic [XAB_W-1:0] dram2_addr,
    output logic dram2_rd,
    input wire logic [NARROW_W-1:0] dram2_rdata,
    // data flash array in the flash module, 16 bits
    output logic [XAB_W-1:0] dflash_addr,
    output logic dflash_rd,
    output logic dflash_wr,
    output logic [NARROW_W-1:0] dflash_wdata,
    input wire logic [NARROW_W-1:0] dflash_rdata,
    // peripheral register bus, 16 bits, flash module control included
    output logic [XAB_W-1:0] periph_addr,
    output logic periph_rd,
    output logic periph_wr,
    output logic [NARROW_W-1:0] periph_wdata,
    input wire logic [NARROW_W-1:0] periph_rdata
);

    function automatic cmb_tgt_type decode_target(input logic [XAB_W-1:0] a);
        if (a >= RAM_BASE && a <= RAM_LAST)
            return CMB_TGT_RAM;
        else if (a >= DFL_BASE && a <= DFL_LAST)
            return CMB_TGT_DFL;
        else if (a >= PER_BASE && a <= PER_LAST)
            return CMB_TGT_PER;
        else
            return CMB_TGT_NONE;
    endfunction

    typedef struct packed {
        logic [PAB_W-1:0] pmem_addr;
        logic pmem_rd;
        logic pmem_wr;
        logic [NARROW_W-1:0] pmem_wdata;
        logic [XAB_W-1:0] dram_addr;
        logic dram_rd;
        logic dram_wr;
        logic [1:0] dram_size;
        logic [WIDE_W-1:0] dram_wdata;
        logic [XAB_W-1:0] dram2_addr;
        logic dram2_rd;
        logic [XAB_W-1:0] dflash_addr;
        logic dflash_rd;
        logic dflash_wr;
        logic [NARROW_W-1:0] dflash_wdata;
        logic [XAB_W-1:0] periph_addr;
        logic periph_rd;
        logic periph_wr;
        logic [NARROW_W-1:0] periph_wdata;
        logic prog_pend;
        cmb_tgt_type prim_tgt;
        logic sec_pend;
        logic [NARROW_W-1:0] prog_data;
        logic [WIDE_W-1:0] prim_data;
        logic [NARROW_W-1:0] sec_data;
    } cmb_state_type;

    cmb_state_type st_q;
    cmb_state_type st_d;
    logic [XAB_W-1:0] eff_addr;
    cmb_tgt_type tgt;
    logic prim_act;

    always_comb
    begin
        eff_addr = primary_data_address_bus;
        if (primary_size == CMB_SIZE_BYTE)
            eff_addr[XAB_MSB] = 1'b0;
        tgt = decode_target(eff_addr);
        prim_act = primary_read_req | primary_write_req;
        st_d = st_q;
        // request strobes are single-cycle
        st_d.pmem_rd = 1'b0;
        st_d.pmem_wr = 1'b0;
        st_d.dram_rd = 1'b0;
        st_d.dram_wr = 1'b0;
        st_d.dram2_rd = 1'b0;
        st_d.dflash_rd = 1'b0;
        st_d.dflash_wr = 1'b0;
        st_d.periph_rd = 1'b0;
        st_d.periph_wr = 1'b0;
        // program path
        st_d.prog_pend = program_read_req;
        if (program_read_req | program_write_req)
        begin
            st_d.pmem_addr = program_address_bus;
            st_d.pmem_rd = program_read_req;
            st_d.pmem_wr = program_write_req & ~program_read_req;
            st_d.pmem_wdata = core_write_bus[NARROW_W-1:0];
        end
        // primary path
        st_d.prim_tgt = CMB_TGT_NONE;
        if (prim_act)
        begin
            st_d.prim_tgt = primary_read_req ? tgt : CMB_TGT_NONE;
            case (tgt)
                CMB_TGT_RAM:
                begin
                    st_d.dram_addr = eff_addr;
                    st_d.dram_size = primary_size;
                    st_d.dram_wdata = core_write_bus;
                    st_d.dram_rd = primary_read_req;
                    st_d.dram_wr = primary_write_req & ~primary_read_req;
                end
                CMB_TGT_DFL:
                begin
                    st_d.dflash_addr = eff_addr;
                    st_d.dflash_wdata = core_write_bus[NARROW_W-1:0];
                    st_d.dflash_rd = primary_read_req;
                    st_d.dflash_wr = primary_write_req & ~primary_read_req;
                end
                CMB_TGT_PER:
                begin
                    st_d.periph_addr = eff_addr;
                    st_d.periph_wdata = core_write_bus[NARROW_W-1:0];
                    st_d.periph_rd = primary_read_req;
                    st_d.periph_wr = primary_write_req & ~primary_read_req;
                end
                default:
                begin
                    st_d.prim_tgt = CMB_TGT_NONE;
                end
            endcase
        end
        // secondary path: word reads from data ram only
        st_d.sec_pend = secondary_read_req;
        if (secondary_read_req)
        begin
            st_d.dram2_addr = secondary_data_address_bus;
            st_d.dram2_rd = 1'b1;
        end
        // return data captured the cycle after the request
        if (st_q.prog_pend)
            st_d.prog_data = pmem_rdata;
        if (st_q.sec_pend)
            st_d.sec_data = dram2_rdata;
        case (st_q.prim_tgt)
            CMB_TGT_RAM: st_d.prim_data = dram_rdata;
            CMB_TGT_DFL: st_d.prim_data = {{NARROW_W{1'b0}}, dflash_rdata};
            CMB_TGT_PER: st_d.prim_data = {{NARROW_W{1'b0}}, periph_rdata};
            default: st_d.prim_data = st_q.prim_data;
        endcase
    end

    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
            st_q <= '0;
        else
            st_q <= st_d;
    end

    assign program_read_bus = st_q.prog_data;
    assign primary_read_bus = st_q.prim_data;
    assign secondary_read_bus = st_q.sec_data;
    assign pmem_addr = st_q.pmem_addr;
    assign pmem_rd = st_q.pmem_rd;
    assign pmem_wr = st_q.pmem_wr;
    assign pmem_wdata = st_q.pmem_wdata;
    assign dram_addr = st_q.dram_addr;
    assign dram_rd = st_q.dram_rd;
    assign dram_wr = st_q.dram_wr;
    assign dram_size = st_q.dram_size;
    assign dram_wdata = st_q.dram_wdata;
    assign dram2_addr = st_q.dram2_addr;
    assign dram2_rd = st_q.dram2_rd;
    assign dflash_addr = st_q.dflash_addr;
    assign dflash_rd = st_q.dflash_rd;
    assign dflash_wr = st_q.dflash_wr;
    assign dflash_wdata = st_q.dflash_wdata;
    assign periph_addr = st_q.periph_addr;
    assign periph_rd = st_q.periph_rd;
    assign periph_wr = st_q.periph_wr;
    assign periph_wdata = st_q.periph_wdata;

    chk_prog_read_addr: assert property (@(posedge clk) disable iff (!reset_n)
        program_read_req |=> pmem_rd && pmem_addr == $past(program_address_bus))
        else $error("program read not forwarded");
    chk_prog_write_low: assert property (@(posedge clk) disable iff (!reset_n)
        program_write_req && !program_read_req
        |=> pmem_wr && pmem_wdata == $past(core_write_bus[NARROW_W-1:0]))
        else $error("program write data wrong");
    chk_ram_route: assert property (@(posedge clk) disable iff (!reset_n)
        primary_read_req && tgt == CMB_TGT_RAM
        |=> dram_rd ##1 primary_read_bus == $past(dram_rdata))
        else $error("ram read not returned");
    chk_periph_route: assert property (@(posedge clk) disable iff (!reset_n)
        prim_act && tgt == CMB_TGT_PER |=> !dram_rd && !dram_wr && (periph_rd || periph_wr))
        else $error("peripheral access misrouted");
    chk_second_read: assert property (@(posedge clk) disable iff (!reset_n)
        secondary_read_req |=> dram2_rd ##1 secondary_read_bus == $past(dram2_rdata))
        else $error("secondary read not returned");
    // antecedent decodes the cleared address itself so a missing clear shows up as no ram strobe
    chk_byte_msb: assert property (@(posedge clk) disable iff (!reset_n)
        prim_act && primary_size == CMB_SIZE_BYTE
        && decode_target({1'b0, primary_data_address_bus[XAB_MSB-1:0]}) == CMB_TGT_RAM
        |=> (dram_rd || dram_wr)
        && dram_addr == {1'b0, $past(primary_data_address_bus[XAB_MSB-1:0])})
        else $error("byte address top bit not cleared");
    chk_periph_nowait: assert property (@(posedge clk) disable iff (!reset_n)
        primary_read_req && tgt == CMB_TGT_PER
        |=> periph_rd ##1 primary_read_bus == {{NARROW_W{1'b0}}, $past(periph_rdata)})
        else $error("peripheral read delayed");
    chk_periph_wdata: assert property (@(posedge clk) disable iff (!reset_n)
        primary_write_req && !primary_read_req && tgt == CMB_TGT_PER
        |=> periph_wr && periph_wdata == $past(core_write_bus[NARROW_W-1:0]))
        else $error("peripheral write data wrong");
    chk_ram_wide: assert property (@(posedge clk) disable iff (!reset_n)
        primary_write_req && !primary_read_req && tgt == CMB_TGT_RAM
        |=> dram_wr && dram_wdata == $past(core_write_bus))
        else $error("ram write data not full width");
    chk_flash_direct: assert property (@(posedge clk) disable iff (!reset_n)
        primary_read_req && tgt == CMB_TGT_DFL |=> dflash_rd && !periph_rd)
        else $error("flash array read misrouted");
    chk_unmapped_none: assert property (@(posedge clk) disable iff (!reset_n)
        prim_act && tgt == CMB_TGT_NONE |=> !dram_rd && !dflash_rd && !periph_rd && !periph_wr)
        else $error("unmapped access reached a target");

endmodule

// ==== bench/cmb_mem_model.sv ====
// Purpose: far-side memories and peripheral registers for the fabric bench
// Assumes: targets answer combinationally while their strobe is high
// Notes: idle read lines show a pattern that changes every cycle
`timescale 1ns/1ps
module cmb_mem_model
    import cmb_pkg::*;
(
    input wire logic clk,
    input wire logic [PAB_W-1:0] pmem_addr,
    input wire logic pmem_rd,
    output logic [NARROW_W-1:0] pmem_rdata,
    input wire logic [XAB_W-1:0] dram_addr,
    input wire logic dram_rd,
    output logic [WIDE_W-1:0] dram_rdata,
    input wire logic [XAB_W-1:0] dram2_addr,
    input wire logic dram2_rd,
    output logic [NARROW_W-1:0] dram2_rdata,
    input wire logic [XAB_W-1:0] dflash_addr,
    input wire logic dflash_rd,
    output logic [NARROW_W-1:0] dflash_rdata,
    input wire logic [XAB_W-1:0] periph_addr,
    input wire logic periph_rd,
    output logic [NARROW_W-1:0] periph_rdata
);
    logic [15:0] junk = 16'h5a5a;
    always @(posedge clk)
    begin
        junk <= ~junk + 16'h0001;
    end
    assign pmem_rdata = pmem_rd ? (pmem_addr[15:0] ^ 16'h1000) : junk;
    assign dram_rdata = dram_rd ? {dram_addr[15:0], ~dram_addr[15:0]} : {junk, junk};
    assign dram2_rdata = dram2_rd ? (dram2_addr[15:0] ^ 16'h2000) : junk;
    assign dflash_rdata = dflash_rd ? (dflash_addr[15:0] ^ 16'h3000) : junk;
    assign periph_rdata = periph_rd ? (periph_addr[15:0] ^ 16'h4000) : junk;
endmodule

// ==== bench/test_cmb_fabric.sv ====
// Purpose: self-checking bench for the core memory bus fabric
// Assumes: strobes one cycle after a request, read buses one cycle later
// Notes: far-side targets come from cmb_mem_model
`timescale 1ns/1ps
module test_cmb_fabric
    import cmb_pkg::*;
;
    logic clk = 1'b0, reset_n = 1'b0;
    logic program_read_req = 1'b0, program_write_req = 1'b0, primary_read_req = 1'b0;
    logic primary_write_req = 1'b0, secondary_read_req = 1'b0;
    logic [PAB_W-1:0] program_address_bus = '0, pmem_addr;
    logic [1:0] primary_size = 2'h1, dram_size;
    logic [XAB_W-1:0] primary_data_address_bus = '0, secondary_data_address_bus = '0;
    logic [XAB_W-1:0] dram_addr, dram2_addr, dflash_addr, periph_addr;
    logic [WIDE_W-1:0] core_write_bus = '0, primary_read_bus, dram_wdata, dram_rdata;
    logic [NARROW_W-1:0] program_read_bus, secondary_read_bus, pmem_wdata, pmem_rdata;
    logic [NARROW_W-1:0] dram2_rdata, dflash_wdata, dflash_rdata, periph_wdata, periph_rdata;
    logic pmem_rd, pmem_wr, dram_rd, dram_wr, dram2_rd, dflash_rd, dflash_wr, periph_rd, periph_wr;
    int n_fail = 0, comparisons = 0;

    cmb_fabric dut (.clk, .reset_n, .program_address_bus, .program_read_req, .program_write_req,
        .program_read_bus, .primary_data_address_bus, .primary_read_req, .primary_write_req,
        .primary_size, .core_write_bus, .primary_read_bus, .secondary_data_address_bus,
        .secondary_read_req, .secondary_read_bus, .pmem_addr, .pmem_rd, .pmem_wr, .pmem_wdata,
        .pmem_rdata, .dram_addr, .dram_rd, .dram_wr, .dram_size, .dram_wdata, .dram_rdata,
        .dram2_addr, .dram2_rd, .dram2_rdata, .dflash_addr, .dflash_rd, .dflash_wr,
        .dflash_wdata, .dflash_rdata, .periph_addr, .periph_rd, .periph_wr, .periph_wdata,
        .periph_rdata);
    cmb_mem_model model (.clk, .pmem_addr, .pmem_rd, .pmem_rdata, .dram_addr, .dram_rd,
        .dram_rdata, .dram2_addr, .dram2_rd, .dram2_rdata, .dflash_addr, .dflash_rd,
        .dflash_rdata, .periph_addr, .periph_rd, .periph_rdata);

    always #20 clk = ~clk;

    task automatic check(input logic [31:0] seen, input logic [31:0] want);
        comparisons++;
        if (seen !== want)
        begin
            n_fail++;
            $display("MISMATCH at %0t: seen %h expected %h", $time, seen, want);
        end
    endtask

    task automatic wrap_up();
        $display("comparisons %0d mismatches %0d", comparisons, n_fail);
        if (n_fail == 0 && comparisons > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    task automatic prim(input logic rd, input logic wr, input logic [1:0] sz,
        input logic [23:0] a, input logic [31:0] d);
        @(posedge clk);
        primary_read_req <= rd;
        primary_write_req <= wr;
        primary_size <= sz;
        primary_data_address_bus <= a;
        core_write_bus <= d;
        @(posedge clk);
        primary_read_req <= 1'b0;
        primary_write_req <= 1'b0;
        #1;
    endtask

    // read wins over the write in the same cycle, then the write goes alone
    task automatic t_program();
        @(posedge clk);
        program_address_bus <= 21'h1abcde;
        program_read_req <= 1'b1;
        program_write_req <= 1'b1;
        core_write_bus <= 32'hdeadbeef;
        @(posedge clk);
        program_read_req <= 1'b0;
        #1;
        check({pmem_rd, pmem_wr, 9'h0, pmem_addr}, {2'b10, 9'h0, 21'h1abcde});
        @(posedge clk);
        program_write_req <= 1'b0;
        #1;
        check({16'h0, program_read_bus}, {16'h0, 16'hacde});
        check({pmem_wr, 15'h0, pmem_wdata}, {1'b1, 15'h0, 16'hbeef});
    endtask

    task automatic rd_case(input logic [1:0] sz, input logic [23:0] a, input logic [2:0] s,
        input logic [31:0] q);
        prim(1'b1, 1'b0, sz, a, 32'h0);
        check({dram_rd, dflash_rd, periph_rd}, {29'h0, s});
        @(posedge clk);
        #1;
        check(primary_read_bus, q);
    endtask

    task automatic t_primary();
        rd_case(CMB_SIZE_LONG, 24'h000123, 3'b100, 32'h0123fedc);
        check({6'h0, dram_size, dram_addr}, {6'h0, 2'b10, 24'h000123});
        rd_case(CMB_SIZE_BYTE, 24'h800124, 3'b100, 32'h0124fedb);
        check(dram_addr, 24'h000124);
        rd_case(CMB_SIZE_WORD, 24'h00f010, 3'b001, 32'h0000b010);
        rd_case(CMB_SIZE_WORD, 24'h004020, 3'b010, 32'h00007020);
        rd_case(CMB_SIZE_WORD, 24'h002000, 3'b000, 32'h00007020);
        // read and write together: the read wins and no write strobe leaves
        prim(1'b1, 1'b1, CMB_SIZE_WORD, 24'h00f006, 32'h0000aaaa);
        check({30'h0, periph_rd, periph_wr}, {30'h0, 2'b10});
        prim(1'b0, 1'b1, CMB_SIZE_WORD, 24'h00f004, 32'h12345678);
        check({periph_wr, dram_wr, 14'h0, periph_wdata}, {2'b10, 14'h0, 16'h5678});
        check({8'h0, periph_addr}, {8'h0, 24'h00f004});
        prim(1'b0, 1'b1, CMB_SIZE_LONG, 24'h000200, 32'hcafef00d);
        check({31'h0, dram_wr}, {31'h0, 1'b1});
        check(dram_wdata, 32'hcafef00d);
        prim(1'b0, 1'b1, CMB_SIZE_WORD, 24'h004010, 32'h0000abcd);
        check({dflash_wr, 15'h0, dflash_wdata}, {1'b1, 15'h0, 16'habcd});
        check({8'h0, dflash_addr}, {8'h0, 24'h004010});
    endtask

    // back-to-back peripheral reads alongside secondary reads, no wait cycles
    task automatic t_dual();
        @(posedge clk);
        primary_read_req <= 1'b1;
        primary_size <= CMB_SIZE_WORD;
        primary_data_address_bus <= 24'h00f030;
        secondary_read_req <= 1'b1;
        secondary_data_address_bus <= 24'h000040;
        @(posedge clk);
        primary_data_address_bus <= 24'h00f032;
        secondary_data_address_bus <= 24'h000042;
        @(posedge clk);
        primary_read_req <= 1'b0;
        secondary_read_req <= 1'b0;
        #1;
        check(primary_read_bus, 32'h0000b030);
        check({16'h0, secondary_read_bus}, {16'h0, 16'h2040});
        @(posedge clk);
        #1;
        check(primary_read_bus, 32'h0000b032);
        check({dram2_rd, 7'h0, dram2_addr}, {1'b0, 7'h0, 24'h000042});
        check({16'h0, secondary_read_bus}, {16'h0, 16'h2042});
    endtask

    initial
    begin
        repeat (5) @(posedge clk);
        reset_n <= 1'b1;
        #1;
        check(primary_read_bus, 32'h0);
        t_program();
        t_primary();
        t_dual();
        wrap_up();
    end

    initial
    begin
        #80000;
        n_fail++;
        wrap_up();
    end
endmodule
